// ### core/ppg_clamp.v
// Input clamp and magnitude split for one colour component
`timescale 1ns/1ps
module ppg_clamp (
    input wire [19:0] pix,
    input wire legacy,
    output reg [18:0] mag,
    output reg neg
);
`include "ppg_defs.vh"

    reg [19:0] abs_v;
    reg [19:0] lim;

    always @*
    begin
        lim = `PPG_MAG_MAX;
        abs_v = pix[19] ? (20'h00000 - pix) : pix;
        mag = 19'h00000;
        neg = 1'b0;
        if (legacy)
        begin
            // Legacy range is 0.0 to 1.0; 1.0 itself maps to top entry
            if (!pix[19])
                mag = (pix[18:0] > `PPG_LEG_MAX) ? `PPG_LEG_MAX : pix[18:0];
        end
        else
        begin
            // Open range: magnitude stays below 7.0
            mag = (abs_v > lim) ? lim[18:0] : abs_v[18:0];
            neg = pix[19];
        end
    end
endmodule

// ### core/ppg_interp.v
// Linear interpolation between two curve points with sign mirroring
`timescale 1ns/1ps
module ppg_interp (
    input wire [18:0] lo,
    input wire [18:0] hi,
    input wire [15:0] w,
    input wire neg,
    output reg [19:0] res
);
`include "ppg_defs.vh"

    reg signed [20:0] diff;
    reg signed [37:0] prod;
    reg signed [37:0] sum;
    reg [18:0] mag;

    always @*
    begin
        diff = $signed({2'b00, hi}) - $signed({2'b00, lo});
        prod = diff * $signed({1'b0, w});
        sum = $signed({3'b000, lo, 16'h0000}) + prod;
        // A falling curve may undershoot zero; hold it at zero
        if (sum[37])
            mag = 19'h00000;
        else if (sum[36:35] != 2'b00)
            mag = `PPG_RES_MAX;
        else
            mag = sum[34:16];
        res = neg ? (20'h00000 - {1'b0, mag}) : {1'b0, mag};
    end
endmodule

// ### core/ppg_top.v
// Pipe palette and gamma unit: APB table access and two-stage pixel path
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module ppg_top #(
    parameter LEG_DEPTH = 256,
    parameter PREC_DEPTH = 1024
) (
    input wire clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire io_pal_wr,
    input wire [7:0] io_pal_addr,
    input wire [23:0] io_pal_data,
    input wire io_pal_6bit,
    input wire in_valid,
    input wire in_gamma_en,
    input wire [19:0] in_r,
    input wire [19:0] in_g,
    input wire [19:0] in_b,
    output wire out_valid,
    output wire [19:0] out_r,
    output wire [19:0] out_g,
    output wire [19:0] out_b
);
`include "ppg_defs.vh"

    // Configuration and tables
    reg [1:0] mode_r;
    reg [7:0] leg_idx_r;
    reg [9:0] prec_idx_r;
    reg [23:0] leg_r [0:LEG_DEPTH-1];
    reg [29:0] prec_r [0:PREC_DEPTH-1];
    reg [16:0] top_r [0:2];
    reg [18:0] ext1_r [0:2];
    reg [18:0] ext2_r [0:2];

    // Pixel pipeline
    reg v1_r;
    reg byp1_r;
    reg [1:0] mode1_r;
    reg [19:0] raw1_r [0:2];
    reg [18:0] mag1_r [0:2];
    reg neg1_r [0:2];
    reg v2_r;
    reg [19:0] out2_r [0:2];

    wire [19:0] in_pix [0:2];
    wire [18:0] mag_w [0:2];
    wire neg_w [0:2];
    wire [19:0] res_w [0:2];

    wire acc = psel & penable & pready;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    wire [23:0] io_word;
    integer i;
    integer j;

    assign in_pix[0] = in_r;
    assign in_pix[1] = in_g;
    assign in_pix[2] = in_b;
    assign out_valid = v2_r;
    assign out_r = out2_r[0];
    assign out_g = out2_r[1];
    assign out_b = out2_r[2];

    // Six-bit I/O colours sit in the top of each 8-bit entry
    assign io_word = io_pal_6bit ?
        {io_pal_data[21:16], 2'b00, io_pal_data[13:8], 2'b00,
         io_pal_data[5:0], 2'b00} : io_pal_data;

    function [9:0] prec_comp;
        input [9:0] idx;
        input [1:0] k;
        begin
            prec_comp = prec_r[idx][10 * (2 - k) +: 10];
        end
    endfunction

    // A 0.16 point is split over an odd/even word pair
    function [18:0] point16;
        input [8:0] pair;
        input [1:0] k;
        reg [9:0] hi_w;
        reg [9:0] lo_w;
        begin
            hi_w = prec_comp({pair, 1'b1}, k);
            lo_w = prec_comp({pair, 1'b0}, k);
            point16 = {3'b000, hi_w, lo_w[9:4]};
        end
    endfunction

    function [9:0] mapped_addr;
        input [7:0] a;
        begin
            mapped_addr = {2'b00, a};
        end
    endfunction

    function known_addr;
        input [7:0] a;
        begin
            known_addr = (a[1:0] == 2'b00) && (a <= `PPG_OFF_EXT2 + 8'h08);
        end
    endfunction

    // APB slave: access without wait states, answer registered in the setup cycle
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~known_addr(paddr);
            prdata <= 32'h00000000;
            if (psel & ~penable & ~pwrite)
            begin
                case (paddr)
                `PPG_OFF_MODE: prdata <= {30'h00000000, mode_r};
                `PPG_OFF_LEG_IDX: prdata <= {24'h000000, leg_idx_r};
                `PPG_OFF_LEG_DATA: prdata <= {8'h00, leg_r[leg_idx_r]};
                `PPG_OFF_PREC_IDX: prdata <= {22'h000000, prec_idx_r};
                `PPG_OFF_PREC_DATA: prdata <= {2'b00, prec_r[prec_idx_r]};
                `PPG_OFF_TOP: prdata <= {15'h0000, top_r[0]};
                `PPG_OFF_TOP + 8'h04: prdata <= {15'h0000, top_r[1]};
                `PPG_OFF_TOP + 8'h08: prdata <= {15'h0000, top_r[2]};
                `PPG_OFF_EXT1: prdata <= {13'h0000, ext1_r[0]};
                `PPG_OFF_EXT1 + 8'h04: prdata <= {13'h0000, ext1_r[1]};
                `PPG_OFF_EXT1 + 8'h08: prdata <= {13'h0000, ext1_r[2]};
                `PPG_OFF_EXT2: prdata <= {13'h0000, ext2_r[0]};
                `PPG_OFF_EXT2 + 8'h04: prdata <= {13'h0000, ext2_r[1]};
                `PPG_OFF_EXT2 + 8'h08: prdata <= {13'h0000, ext2_r[2]};
                default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Register writes; stored values are the low bits, software clamps
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mode_r <= `PPG_MODE_RST;
            leg_idx_r <= 8'h00;
            prec_idx_r <= 10'h000;
            for (i = 0; i < 3; i = i + 1)
            begin
                top_r[i] <= 17'h00000;
                ext1_r[i] <= 19'h00000;
                ext2_r[i] <= 19'h00000;
            end
        end
        else if (wr)
        begin
            case (paddr)
            `PPG_OFF_MODE: mode_r <= pwdata[1:0];
            `PPG_OFF_LEG_IDX: leg_idx_r <= pwdata[7:0];
            `PPG_OFF_LEG_DATA: leg_idx_r <= leg_idx_r + 8'h01;
            `PPG_OFF_PREC_IDX: prec_idx_r <= pwdata[9:0];
            `PPG_OFF_PREC_DATA: prec_idx_r <= prec_idx_r + 10'h001;
            `PPG_OFF_TOP: top_r[0] <= pwdata[16:0];
            `PPG_OFF_TOP + 8'h04: top_r[1] <= pwdata[16:0];
            `PPG_OFF_TOP + 8'h08: top_r[2] <= pwdata[16:0];
            `PPG_OFF_EXT1: ext1_r[0] <= pwdata[18:0];
            `PPG_OFF_EXT1 + 8'h04: ext1_r[1] <= pwdata[18:0];
            `PPG_OFF_EXT1 + 8'h08: ext1_r[2] <= pwdata[18:0];
            `PPG_OFF_EXT2: ext2_r[0] <= pwdata[18:0];
            `PPG_OFF_EXT2 + 8'h04: ext2_r[1] <= pwdata[18:0];
            `PPG_OFF_EXT2 + 8'h08: ext2_r[2] <= pwdata[18:0];
            default: mode_r <= mode_r;
            endcase
        end
        else if (rd)
        begin
            // Reading a data word also steps its index
            if (paddr == `PPG_OFF_LEG_DATA)
                leg_idx_r <= leg_idx_r + 8'h01;
            if (paddr == `PPG_OFF_PREC_DATA)
                prec_idx_r <= prec_idx_r + 10'h001;
        end
    end

    // Table storage; the APB write takes the entry over an I/O write
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (j = 0; j < LEG_DEPTH; j = j + 1)
                leg_r[j] <= 24'h000000;
            for (j = 0; j < PREC_DEPTH; j = j + 1)
                prec_r[j] <= 30'h00000000;
        end
        else
        begin
            if (wr && paddr == `PPG_OFF_LEG_DATA)
                leg_r[leg_idx_r] <= pwdata[23:0];
            else if (io_pal_wr)
                leg_r[io_pal_addr] <= io_word;
            if (wr && paddr == `PPG_OFF_PREC_DATA)
                prec_r[prec_idx_r] <= pwdata[29:0];
        end
    end

    // Pipeline control: valid of both stages, stage 1 bypass choice and the mode in force
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            v1_r <= 1'b0;
            byp1_r <= 1'b0;
            mode1_r <= `PPG_MODE_RST;
            v2_r <= 1'b0;
        end
        else
        begin
            v1_r <= in_valid;
            byp1_r <= ~in_gamma_en;
            mode1_r <= mode_r;
            v2_r <= v1_r;
        end
    end

    genvar k;
    generate
        for (k = 0; k < 3; k = k + 1)
        begin : g_comp
            reg [18:0] lo;
            reg [18:0] hi;
            reg [15:0] w;
            reg [18:0] m;
            reg [18:0] d1;
            reg [18:0] d3;
            reg [9:0] c10;
            reg [7:0] c8;
            reg [8:0] p9;

            ppg_clamp u_clamp (
                .pix(in_pix[k]),
                .legacy(mode_r == `PPG_MODE_LEGACY),
                .mag(mag_w[k]),
                .neg(neg_w[k])
            );

            always @(posedge clk or posedge rst)
            begin
                if (rst)
                begin
                    raw1_r[k] <= 20'h00000;
                    mag1_r[k] <= 19'h00000;
                    neg1_r[k] <= 1'b0;
                    out2_r[k] <= 20'h00000;
                end
                else
                begin
                    raw1_r[k] <= in_pix[k];
                    mag1_r[k] <= mag_w[k];
                    neg1_r[k] <= neg_w[k];
                    out2_r[k] <= byp1_r ? raw1_r[k] : res_w[k];
                end
            end

            // Pick the two curve points and the weight for this component
            always @*
            begin
                m = mag1_r[k];
                d1 = m - `PPG_ONE;
                d3 = m - `PPG_THREE;
                c8 = leg_r[m[15:8]][8 * (2 - k) +: 8];
                c10 = prec_comp(m[15:6], k);
                p9 = m[15:7];
                lo = 19'h00000;
                hi = 19'h00000;
                w = 16'h0000;
                case (mode1_r)
                `PPG_MODE_LEGACY:
                begin
                    lo = {3'b000, c8, 8'h00};
                    hi = lo;
                end
                `PPG_MODE_DIRECT, `PPG_MODE_INTERP, `PPG_MODE_MULTI:
                begin
                    if (m >= `PPG_THREE)
                    begin
                        lo = ext1_r[k];
                        hi = ext2_r[k];
                        w = d3[17:2];
                    end
                    else if (m >= `PPG_ONE)
                    begin
                        if (mode1_r == `PPG_MODE_DIRECT)
                            lo = {3'b000, prec_comp(10'h3FF, k), 6'h00};
                        else
                            lo = {2'b00, top_r[k]};
                        hi = ext1_r[k];
                        w = d1[16:1];
                    end
                    else if (mode1_r == `PPG_MODE_DIRECT)
                    begin
                        lo = {3'b000, c10, 6'h00};
                        hi = lo;
                    end
                    else if (mode1_r == `PPG_MODE_INTERP)
                    begin
                        // 512 equal steps below 1.0, top step ends at 513th
                        lo = point16(p9, k);
                        hi = (p9 == 9'h1FF) ? {2'b00, top_r[k]} :
                            point16(p9 + 9'h001, k);
                        w = {m[6:0], 9'h000};
                    end
                    else if (m[15:9] == 7'h00)
                    begin
                        // Fine segment: zero point is implied
                        lo = (m[8:1] == 8'h00) ? 19'h00000 :
                            point16({1'b0, m[8:1] - 8'h01}, k);
                        hi = point16({1'b0, m[8:1]}, k);
                        w = {m[0], 15'h0000};
                    end
                    else
                    begin
                        // Coarse segment lives in the upper half of the table
                        lo = point16({1'b1, m[15:8]}, k);
                        hi = (m[15:8] == 8'hFF) ? {2'b00, top_r[k]} :
                            point16({1'b1, m[15:8] + 8'h01}, k);
                        w = {m[7:0], 8'h00};
                    end
                end
                default:
                begin
                    lo = 19'h00000;
                    hi = 19'h00000;
                end
                endcase
            end

            ppg_interp u_interp (
                .lo(lo),
                .hi(hi),
                .w(w),
                .neg(neg1_r[k]),
                .res(res_w[k])
            );
        end
    endgenerate
endmodule

// ### include/ppg_defs.vh
// Register map, mode codes and fixed-point limits of the pipe palette unit
`ifndef PPG_DEFS_VH
`define PPG_DEFS_VH

`define PPG_OFF_MODE 8'h00
`define PPG_OFF_LEG_IDX 8'h04
`define PPG_OFF_LEG_DATA 8'h08
`define PPG_OFF_PREC_IDX 8'h0C
`define PPG_OFF_PREC_DATA 8'h10
`define PPG_OFF_TOP 8'h14
`define PPG_OFF_EXT1 8'h20
`define PPG_OFF_EXT2 8'h2C

`define PPG_MODE_LEGACY 2'h0
`define PPG_MODE_DIRECT 2'h1
`define PPG_MODE_INTERP 2'h2
`define PPG_MODE_MULTI 2'h3
`define PPG_MODE_RST 2'h0

`define PPG_ONE 19'h10000
`define PPG_THREE 19'h30000
`define PPG_LEG_MAX 19'h0FFFF
`define PPG_MAG_MAX 20'h6FFFF
`define PPG_RES_MAX 19'h7FFFF

`endif

// ### sim/ppg_blender_model.sv
// Upstream blender model feeding blended pixels to the palette unit
`timescale 1ns/1ps
module ppg_blender_model (
    input wire clk,
    output reg in_valid,
    output reg in_gamma_en,
    output reg [19:0] in_r,
    output reg [19:0] in_g,
    output reg [19:0] in_b
);
    initial
    begin
        in_valid = 1'b0;
        in_gamma_en = 1'b0;
        in_r = 20'h00000;
        in_g = 20'h00000;
        in_b = 20'h00000;
    end
    // One pixel for one cycle, its plane's gamma enable beside it
    task send(input logic en, input logic [19:0] r, g, b);
    begin
        @(posedge clk);
        in_valid <= 1'b1;
        in_gamma_en <= en;
        in_r <= r;
        in_g <= g;
        in_b <= b;
        @(posedge clk);
        in_valid <= 1'b0;
        // Idle data never repeats the pixel, so stale use shows up
        in_r <= ~r;
        in_g <= ~g;
        in_b <= ~b;
    end
    endtask
endmodule

// ### sim/ppg_checker_properties.sv
// Port-level assertions for the pipe palette unit
`timescale 1ns/1ps
`include "ppg_defs.vh"
module ppg_checker (
    input wire clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire in_valid,
    input wire in_gamma_en,
    input wire [19:0] in_r,
    input wire out_valid,
    input wire [19:0] out_r
);
    reg [1:0] mode_r;
    wire mode_wr;
    // Shadow of the mode field, taken at the same edge as the unit does
    assign mode_wr = psel && penable && pready && pwrite
        && paddr == `PPG_OFF_MODE;
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            mode_r <= `PPG_MODE_RST;
        else if (mode_wr)
            mode_r <= pwdata[1:0];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_pix(m);
        in_valid && in_gamma_en && mode_r == m;
    endsequence
    sequence s_ext;
        in_valid && in_gamma_en && mode_r != `PPG_MODE_LEGACY;
    endsequence
    property p_ready;
        s_setup |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready");
    property p_no_ready;
        !(psel && !penable) |=> !pready;
    endproperty
    a_no_ready: assert property (p_no_ready) else $error("stray ready");
    property p_err;
        pready && (paddr > 8'h34 || paddr[1:0] != 2'h0) |-> pslverr;
    endproperty
    a_err: assert property (p_err) else $error("no slave error");
    property p_lat;
        in_valid |-> ##2 out_valid;
    endproperty
    a_lat: assert property (p_lat) else $error("pixel lost");
    property p_idle;
        !in_valid |-> ##2 !out_valid;
    endproperty
    a_idle: assert property (p_idle) else $error("stray pixel");
    property p_bypass;
        in_valid && !in_gamma_en |-> ##2 out_r == $past(in_r, 2);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass");
    property p_legacy;
        s_pix(`PPG_MODE_LEGACY) |-> ##2
            (out_r[19:16] == 4'h0 && out_r[7:0] == 8'h00);
    endproperty
    a_legacy: assert property (p_legacy) else $error("legacy form");
    property p_direct;
        s_pix(`PPG_MODE_DIRECT) ##0 in_r < 20'h10000 |-> ##2
            (out_r[19:16] == 4'h0 && out_r[5:0] == 6'h00);
    endproperty
    a_direct: assert property (p_direct) else $error("direct form");
    property p_mirror;
        s_ext ##0 in_r[19] |-> ##2 (out_r[19] || out_r == 20'h00000);
    endproperty
    a_mirror: assert property (p_mirror) else $error("sign lost");
    property p_pos;
        s_ext ##0 !in_r[19] |-> ##2 !out_r[19];
    endproperty
    a_pos: assert property (p_pos) else $error("sign flip");
endmodule

// ### sim/ppg_top_tb_top.sv
// Self-checking bench for the pipe palette unit
`timescale 1ns/1ps
`include "ppg_defs.vh"
module ppg_top_tb_top;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg io_pal_wr = 1'b0;
    reg [7:0] io_pal_addr = 8'h00;
    reg [23:0] io_pal_data = 24'h0;
    reg io_pal_6bit = 1'b0;
    reg gen = 1'b1;
    wire [31:0] prdata;
    wire pready, pslverr, in_valid, in_gamma_en, out_valid;
    wire [19:0] in_r, in_g, in_b, out_r, out_g, out_b;
    integer fails = 0;
    integer n_compared = 0;
    integer i;
    reg [31:0] rd;
    reg err;
    logic [19:0] t_in [10] = '{20'h20000, 20'hE0000, 20'h50000,
        20'h7FFFF, 20'h80000, 20'h00040, 20'h00000, 20'h0FFC0,
        20'h20000, 20'h50000};
    logic [19:0] t_exp [10] = '{20'h1FFE0, 20'hE0020, 20'h50000,
        20'h6FFFC, 20'h90004, 20'h0023F, 20'h0007F, 20'h0FFE0,
        20'h20000, 20'h50000};
    always #5 clk = ~clk;
    ppg_top dut_u (.clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .io_pal_wr, .io_pal_addr,
        .io_pal_data, .io_pal_6bit, .in_valid, .in_gamma_en, .in_r,
        .in_g, .in_b, .out_valid, .out_r, .out_g, .out_b);
    ppg_blender_model blender_u (.clk, .in_valid, .in_gamma_en,
        .in_r, .in_g, .in_b);
    task check(input string what, input logic [31:0] seen, exp);
    begin
        n_compared = n_compared + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    end
    endtask
    task give_verdict;
    begin
        if (fails == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask
    // Holds the request until pready is seen; the watchdog ends a hang
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    begin
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Look between edges so the answer is settled, not racing its edge
        #1;
        while (pready !== 1'b1)
        begin
            @(posedge clk);
            #1;
        end
        rd = prdata;
        err = pslverr;
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdchk(input string what, input logic [7:0] a, input [31:0] e);
    begin
        apb(1'b0, a, 32'h0);
        check(what, rd, e);
    end
    endtask
    task pix(input logic [19:0] r, gb, er, eg, eb);
    begin
        blender_u.send(gen, r, gb, gb);
        @(posedge clk);
        #1;
        check("out_r", {12'h0, out_r}, {12'h0, er});
        check("out_g", {12'h0, out_g}, {12'h0, eg});
        check("out_b", {12'h0, out_b}, {12'h0, eb});
    end
    endtask
    initial
    begin
        #100000;
        fails = fails + 1;
        give_verdict;
    end
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdchk("ext1", `PPG_OFF_EXT1, 32'h0);
        apb(1'b1, 8'h01, 32'h3);
        check("err", {31'h0, err}, 32'h1);
        rdchk("gap", 8'h38, 32'h0);
        check("err", {31'h0, err}, 32'h1);
        rdchk("mode", `PPG_OFF_MODE, 32'h0);
        for (i = 0; i < 4; i++)
        begin
            wr(`PPG_OFF_MODE, 32'hFFFFFFFC | i);
            rdchk("mode", `PPG_OFF_MODE, i);
        end
        wr(`PPG_OFF_EXT1, 32'hFFFFFFFF);
        rdchk("ext1", `PPG_OFF_EXT1, 32'h7FFFF);
        wr(`PPG_OFF_TOP, 32'hFFFFFFFF);
        rdchk("top", `PPG_OFF_TOP, 32'h1FFFF);
        wr(`PPG_OFF_MODE, 32'h0);
        wr(`PPG_OFF_LEG_IDX, 32'h10);
        wr(`PPG_OFF_LEG_DATA, 32'h112233);
        wr(`PPG_OFF_LEG_DATA, 32'h445566);
        wr(`PPG_OFF_LEG_IDX, 32'h10);
        rdchk("leg", `PPG_OFF_LEG_DATA, 32'h112233);
        rdchk("leg", `PPG_OFF_LEG_DATA, 32'h445566);
        rdchk("idx", `PPG_OFF_LEG_IDX, 32'h12);
        @(posedge clk);
        io_pal_wr <= 1'b1;
        io_pal_addr <= 8'hFF;
        io_pal_data <= 24'h3F2001;
        io_pal_6bit <= 1'b1;
        @(posedge clk);
        io_pal_wr <= 1'b0;
        wr(`PPG_OFF_LEG_IDX, 32'hFF);
        rdchk("io", `PPG_OFF_LEG_DATA, 32'hFC8004);
        pix(20'h01000, 20'h01100, 20'h01100, 20'h05500, 20'h06600);
        pix(20'h1FF00, 20'hFFFFF, 20'h0FC00, 20'h0, 20'h0);
        gen = 1'b0;
        pix(20'h12345, 20'hFEDCB, 20'h12345, 20'hFEDCB, 20'hFEDCB);
        gen = 1'b1;
        wr(`PPG_OFF_MODE, 32'h1);
        wr(`PPG_OFF_PREC_IDX, 32'h3FF);
        wr(`PPG_OFF_PREC_DATA, 32'h3FF80001);
        wr(`PPG_OFF_EXT1, 32'h30000);
        wr(`PPG_OFF_EXT2, 32'h70000);
        pix(20'h0FFC0, 20'h0FFC0, 20'h0FFC0, 20'h08000, 20'h00040);
        for (i = 0; i < 10; i++)
        begin
            if (i == 5)
            begin
                wr(`PPG_OFF_MODE, 32'h2);
                wr(`PPG_OFF_PREC_IDX, 32'h0);
                wr(`PPG_OFF_PREC_DATA, 32'h3F000000);
                wr(`PPG_OFF_PREC_DATA, 32'h00100000);
                wr(`PPG_OFF_PREC_DATA, 32'h0);
                wr(`PPG_OFF_PREC_DATA, 32'h01000000);
                wr(`PPG_OFF_TOP, 32'h10000);
            end
            pix(t_in[i], 20'h0, t_exp[i], 20'h0, 20'h0);
        end
        wr(`PPG_OFF_MODE, 32'h3);
        pix(20'h00002, 20'h0, 20'h0007F, 20'h0, 20'h0);
        pix(20'h0FFC0, 20'h0, 20'h0FFF0, 20'h0, 20'h0);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rdchk("mode", `PPG_OFF_MODE, 32'h0);
        rdchk("ext2", `PPG_OFF_EXT2, 32'h0);
        give_verdict;
    end
endmodule
bind ppg_top ppg_checker chk_u (.clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .in_valid, .in_gamma_en,
    .in_r, .out_valid, .out_r);
